/* File: src/ddsl_serial_latch.sv */
// Serial input shifter and latch control of the dual converter
// Behaviour
// [R01] While chip select is low the 16-bit input shift register takes bits, MSB first.
// [R02] Serial data is sampled and shifted on each falling edge of the serial clock.
// [R03] A rising chip select moves the shifted word into the latches per the program bits.
// [R04] The host raises chip select only while the serial clock is high.
// [R05] Word is four program bits on top, ten data bits 11 to 2, two ignored fill bits.
// [R06] Latch A select set loads data into latch A and buffer into latch B, buffer kept.
// [R07] Latch A select clear and buffer-only clear load data into latch B and the buffer.
// [R08] Latch A select clear and buffer-only set load data into the buffer alone.
// [R09] Speed select 1 means slow settling, 0 fast; power-down 1 powers down, 0 runs.
// [R10] Latch transfers happen right after chip select rises, never earlier; the counting variant transfers at count end, before chip select rises.
// [R11] The host keeps the speed bit as in its previous write; the bench sets it in its fourth write after three writes with it clear.
// [R12] Counting variant counts 16 clocks after chip select falls, then ignores input.
// [R13] Counting variant ends the write on count end or an earlier chip select rise.
// [R14] Byte hosts send a word as two bytes in one chip select low period.
// [R15] At power-up all converter latches are cleared to zero.
// [R16] The host raises the serial clock after the sixteenth falling edge before ending.
// [R17] Without counting, only the last sixteen bits shifted in are kept.
module ddsl_serial_latch #(
  parameter bit COUNT_VARIANT = 1'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Serial pins
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data,
  // Receiver stall for latch words
  input wire logic out_ready,
  // Converter latches and mode
  output logic [ddsl_pkg::DATA_W-1:0] latch_a_q,
  output logic [ddsl_pkg::DATA_W-1:0] latch_b_q,
  output logic [ddsl_pkg::DATA_W-1:0] double_buffer_q,
  output logic slow_settling_q,
  output logic powered_down_q,
  output logic update_q
);
  // Falling edge of a synchronised level
  function automatic logic edge_fall(input logic prev, input logic now);
    edge_fall = prev & ~now;
  endfunction

  // Rising edge of a synchronised level
  function automatic logic edge_rise(input logic prev, input logic now);
    edge_rise = ~prev & now;
  endfunction

  // Next value of a buffer pointer
  function automatic logic ptr_next(input logic ptr, input logic step);
    ptr_next = step ? ~ptr : ptr;
  endfunction

  // Pin synchronisers
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] sdi_sync_q;
  // Edge finders
  logic cs_prev_q;
  logic sck_prev_q;
  // Shifter, counter and lock
  logic [ddsl_pkg::WORD_W-1:0] input_shift_register_q;
  logic [ddsl_pkg::WORD_W-1:0] input_shift_register_d;
  logic [ddsl_pkg::CNT_W-1:0] bit_count_q;
  logic [ddsl_pkg::CNT_W-1:0] bit_count_d;
  logic locked_q;
  logic locked_d;
  // Two-entry buffer of finished words
  ddsl_pkg::ddsl_word_t buf_q [2];
  logic [1:0] buf_cnt_q;
  logic [1:0] buf_cnt_d;
  logic rd_ptr_q;
  logic rd_ptr_d;
  logic wr_ptr_q;
  logic wr_ptr_d;
  // Latch next values
  logic [ddsl_pkg::DATA_W-1:0] latch_a_d;
  logic [ddsl_pkg::DATA_W-1:0] latch_b_d;
  logic [ddsl_pkg::DATA_W-1:0] double_buffer_d;
  logic slow_settling_d;
  logic powered_down_d;

  // Chip select synchroniser, idles deselected
  always_ff @(posedge clock) begin
    if (reset) begin
      cs_sync_q <= 2'h3;
    end else begin
      cs_sync_q <= {cs_sync_q[0], chip_select_n};
    end
  end

  // Serial clock synchroniser, idles low
  always_ff @(posedge clock) begin
    if (reset) begin
      sck_sync_q <= 2'h0;
    end else begin
      sck_sync_q <= {sck_sync_q[0], serial_clock};
    end
  end

  // Serial data synchroniser
  always_ff @(posedge clock) begin
    if (reset) begin
      sdi_sync_q <= 2'h0;
    end else begin
      sdi_sync_q <= {sdi_sync_q[0], serial_data};
    end
  end

  logic cs_n;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic count_done;
  logic shift_en;
  logic write_end;
  assign cs_n = cs_sync_q[1];
  assign sck_fall = edge_fall(sck_prev_q, sck_sync_q[1]);
  assign cs_fall = edge_fall(cs_prev_q, cs_n);
  assign cs_rise = edge_rise(cs_prev_q, cs_n);
  assign count_done = COUNT_VARIANT && (bit_count_q == ddsl_pkg::WORD_BITS);
  assign shift_en = ~cs_n & sck_fall & ~locked_q; // [R01] [R02] [R12]
  // Write ends on chip select rise, or on count end in counting variant
  assign write_end = (cs_rise & ~locked_q) | (count_done & ~locked_q); // [R03] [R13]

  // Oldest bit falls off the top
  assign input_shift_register_d = shift_en ?
      {input_shift_register_q[ddsl_pkg::WORD_W-2:0], sdi_sync_q[1]} :
      input_shift_register_q; // [R01] [R17]
  assign bit_count_d = cs_fall ? '0 :
      ((shift_en && COUNT_VARIANT) ? bit_count_q + 1'h1 : bit_count_q); // [R12]
  assign locked_d = cs_fall ? 1'h0 : (write_end ? 1'h1 : locked_q); // [R12] [R13]

  ddsl_pkg::ddsl_word_t word_in;
  assign word_in.latch_a_select_bit = input_shift_register_q[ddsl_pkg::LATCH_A_SEL_POS]; // [R05]
  assign word_in.speed_select_bit = input_shift_register_q[ddsl_pkg::SPEED_SEL_POS];
  assign word_in.power_down_bit = input_shift_register_q[ddsl_pkg::POWER_DOWN_POS];
  assign word_in.buffer_only_bit = input_shift_register_q[ddsl_pkg::BUF_ONLY_POS];
  assign word_in.data = input_shift_register_q[ddsl_pkg::DATA_MSB_POS:ddsl_pkg::DATA_LSB_POS];

  // Buffer occupancy; a word arriving while full is dropped
  logic buf_full;
  logic buf_empty;
  logic push;
  logic pop;
  ddsl_pkg::ddsl_word_t head;
  assign buf_full = (buf_cnt_q == 2'h2);
  assign buf_empty = (buf_cnt_q == 2'h0);
  assign push = write_end & ~buf_full;
  assign pop = ~buf_empty & out_ready;
  assign head = buf_q[rd_ptr_q];
  assign buf_cnt_d = buf_cnt_q + {1'h0, push} - {1'h0, pop};
  assign wr_ptr_d = ptr_next(wr_ptr_q, push);
  assign rd_ptr_d = ptr_next(rd_ptr_q, pop);

  // Latch selection from the program bits of the head word
  logic load_a;
  logic load_b;
  logic load_buffer;
  assign load_a = pop & head.latch_a_select_bit; // [R06]
  assign load_b = pop & ~head.latch_a_select_bit & ~head.buffer_only_bit; // [R07]
  assign load_buffer = pop & ~head.latch_a_select_bit; // [R07] [R08]
  assign latch_a_d = load_a ? head.data : latch_a_q; // [R06]
  assign latch_b_d = load_a ? double_buffer_q :
      (load_b ? head.data : latch_b_q); // [R06] [R07]
  assign double_buffer_d = load_buffer ? head.data : double_buffer_q; // [R07] [R08]
  assign slow_settling_d = pop ? head.speed_select_bit : slow_settling_q; // [R09]
  assign powered_down_d = pop ? head.power_down_bit : powered_down_q; // [R09]

  // Edge finder registers
  always_ff @(posedge clock) begin
    if (reset) begin
      cs_prev_q <= 1'h1;
      sck_prev_q <= 1'h0;
    end else begin
      cs_prev_q <= cs_n;
      sck_prev_q <= sck_sync_q[1];
    end
  end

  // Input shift register
  always_ff @(posedge clock) begin
    if (reset) begin
      input_shift_register_q <= ddsl_pkg::WORD_RESET;
    end else begin
      input_shift_register_q <= input_shift_register_d;
    end
  end

  // Bit counter and input lock
  always_ff @(posedge clock) begin
    if (reset) begin
      bit_count_q <= '0;
      locked_q <= 1'h0;
    end else begin
      bit_count_q <= bit_count_d;
      locked_q <= locked_d;
    end
  end

  // Buffer storage
  always_ff @(posedge clock) begin
    if (reset) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[wr_ptr_q] <= word_in;
    end
  end

  // Buffer pointers and count
  always_ff @(posedge clock) begin
    if (reset) begin
      buf_cnt_q <= 2'h0;
      rd_ptr_q <= 1'h0;
      wr_ptr_q <= 1'h0;
    end else begin
      buf_cnt_q <= buf_cnt_d;
      rd_ptr_q <= rd_ptr_d;
      wr_ptr_q <= wr_ptr_d;
    end
  end

  // Converter latches, applied once the word leaves the buffer
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_a_q <= ddsl_pkg::LATCH_RESET; // [R15]
      latch_b_q <= ddsl_pkg::LATCH_RESET; // [R15]
      double_buffer_q <= ddsl_pkg::LATCH_RESET; // [R15]
    end else begin
      latch_a_q <= latch_a_d;
      latch_b_q <= latch_b_d;
      double_buffer_q <= double_buffer_d;
    end
  end

  // Mode bits and update strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      slow_settling_q <= 1'h0;
      powered_down_q <= 1'h0;
      update_q <= 1'h0;
    end else begin
      slow_settling_q <= slow_settling_d;
      powered_down_q <= powered_down_d;
      update_q <= pop; // [R10]
    end
  end
endmodule

/* File: src/ddsl_pkg.sv */
// Package for the dual converter serial input and latch control
package ddsl_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 10;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
  localparam int LATCH_A_SEL_POS = 15;
  localparam int SPEED_SEL_POS = 14;
  localparam int POWER_DOWN_POS = 13;
  localparam int BUF_ONLY_POS = 12;
  localparam int DATA_MSB_POS = 11;
  localparam int DATA_LSB_POS = 2;
  localparam logic [DATA_W-1:0] LATCH_RESET = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // Decoded program bits and data of one word
  typedef struct packed {
    logic latch_a_select_bit;
    logic speed_select_bit;
    logic power_down_bit;
    logic buffer_only_bit;
    logic [DATA_W-1:0] data;
  } ddsl_word_t;
endpackage

/* File: verif/ddsl_host.sv */
// Host serial port model driving the converter pins
module ddsl_host (
  // Clock
  input wire logic clock,
  // Serial pins
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select_n = 1'h1;
    serial_clock = 1'h0;
    serial_data = 1'h0;
  end
  // Sends low n bits of v, MSB first, 80 ns link clock
  task automatic send(input logic [31:0] v, input int n);
    chip_select_n <= 1'h0;
    repeat (4) @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      if (i == 7 && n == 16) begin
        repeat (8) @(posedge clock);
      end
      serial_clock <= 1'h1;
      serial_data <= v[i];
      repeat (4) @(posedge clock);
      serial_clock <= 1'h0;
      repeat (4) @(posedge clock);
    end
    serial_clock <= 1'h1;
    repeat (4) @(posedge clock);
    chip_select_n <= 1'h1;
    repeat (4) @(posedge clock);
    serial_clock <= 1'h0;
    repeat (12) @(posedge clock);
  endtask
endmodule

/* File: verif/ddsl_chk.sv */
// Checker of latch transfers and mode outputs
module ddsl_chk #(
  parameter bit COUNT_VARIANT = 1'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pins and stall
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic out_ready,
  // Latches and mode
  input wire logic [ddsl_pkg::DATA_W-1:0] latch_a_q,
  input wire logic [ddsl_pkg::DATA_W-1:0] latch_b_q,
  input wire logic [ddsl_pkg::DATA_W-1:0] double_buffer_q,
  input wire logic slow_settling_q,
  input wire logic powered_down_q,
  input wire logic update_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_upd_after: assert property (
    $changed({latch_a_q, latch_b_q, double_buffer_q}) |-> update_q) else $error("no update");
  chk_stall_hold: assert property (
    !out_ready |=> $stable({latch_a_q, latch_b_q, double_buffer_q})) else $error("stall lost");
  chk_a_write: assert property (
    $changed(latch_a_q) |-> latch_b_q == $past(double_buffer_q) && $stable(double_buffer_q))
    else $error("bad latch A write");
  chk_b_write: assert property (
    $changed(latch_b_q) && $stable(latch_a_q) |-> latch_b_q == double_buffer_q)
    else $error("bad latch B write");
  chk_buf_only: assert property (
    $changed(double_buffer_q) && double_buffer_q != latch_b_q |-> $stable(latch_a_q)
    && $stable(latch_b_q)) else $error("bad buffer write");
  chk_reset_zero: assert property (
    $past(reset) |-> {latch_a_q, latch_b_q, double_buffer_q, update_q} == 31'h0)
    else $error("not cleared");
  chk_mode_upd: assert property (
    $changed(slow_settling_q) || $changed(powered_down_q) |-> update_q) else $error("mode");
  chk_cs_answer: assert property (
    !COUNT_VARIANT && $rose(chip_select_n) && out_ready |-> ##[1:6] update_q)
    else $error("no answer");
endmodule
bind ddsl_serial_latch ddsl_chk #(.COUNT_VARIANT(COUNT_VARIANT)) ddsl_chk_inst (.clock,
  .reset, .chip_select_n, .serial_clock,
  .serial_data, .out_ready, .latch_a_q, .latch_b_q, .double_buffer_q, .slow_settling_q,
  .powered_down_q, .update_q);

/* File: verif/tb.sv */
// Self-checking bench for the serial input and latch control
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic out_ready = 1'h1;
  logic chip_select_n;
  logic serial_clock;
  logic serial_data;
  logic slow_settling_q;
  logic powered_down_q;
  logic update_q;
  logic [ddsl_pkg::DATA_W-1:0] latch_a_q;
  logic [ddsl_pkg::DATA_W-1:0] latch_b_q;
  logic [ddsl_pkg::DATA_W-1:0] double_buffer_q;
  logic cnt_slow_q;
  logic cnt_down_q;
  logic cnt_update_q;
  logic [ddsl_pkg::DATA_W-1:0] cnt_a_q;
  logic [ddsl_pkg::DATA_W-1:0] cnt_b_q;
  logic [ddsl_pkg::DATA_W-1:0] cnt_buf_q;
  logic [31:0] seen;
  logic [31:0] seen_cnt;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  assign seen = {latch_a_q, latch_b_q, double_buffer_q, slow_settling_q, powered_down_q};
  assign seen_cnt = {cnt_a_q, cnt_b_q, cnt_buf_q, cnt_slow_q, cnt_down_q};
  initial begin
    forever begin
      #5 clock = ~clock;
    end
  end
  ddsl_host ddsl_host_inst (.clock, .chip_select_n, .serial_clock, .serial_data);
  ddsl_serial_latch ddsl_serial_latch_inst (.clock, .reset, .chip_select_n, .serial_clock,
    .serial_data, .out_ready, .latch_a_q, .latch_b_q, .double_buffer_q, .slow_settling_q,
    .powered_down_q, .update_q);
  ddsl_serial_latch #(.COUNT_VARIANT(1'h1)) ddsl_serial_latch_cnt_inst (.clock, .reset,
    .chip_select_n, .serial_clock, .serial_data, .out_ready, .latch_a_q(cnt_a_q),
    .latch_b_q(cnt_b_q), .double_buffer_q(cnt_buf_q), .slow_settling_q(cnt_slow_q),
    .powered_down_q(cnt_down_q), .update_q(cnt_update_q));
  task automatic end_sim;
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic expect_out(input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      bad_count++;
      $display("BAD latches expected %h seen %h", e, seen);
    end
  endtask
  task automatic expect_cnt(input logic [31:0] e);
    checked++;
    if (seen_cnt !== e) begin
      bad_count++;
      $display("BAD count_latches expected %h seen %h", e, seen_cnt);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    repeat (4) @(posedge clock);
    expect_out(32'h0);
    expect_cnt(32'h0);
    ddsl_host_inst.send(32'h0AAB, 16);
    expect_out({10'h000, 10'h2AA, 10'h2AA, 2'h0});
    ddsl_host_inst.send(32'h1554, 16);
    expect_out({10'h000, 10'h2AA, 10'h155, 2'h0});
    ddsl_host_inst.send(32'h8FFC, 16);
    expect_out({10'h3FF, 10'h155, 10'h155, 2'h0});
    ddsl_host_inst.send(32'h6004, 16);
    expect_out({10'h3FF, 10'h001, 10'h001, 2'h3});
    expect_cnt({10'h3FF, 10'h001, 10'h001, 2'h3});
    ddsl_host_inst.send(32'hF43C0, 20);
    expect_out({10'h3FF, 10'h0F0, 10'h0F0, 2'h2});
    expect_cnt({10'h10F, 10'h001, 10'h001, 2'h3});
    out_ready <= 1'h0;
    ddsl_host_inst.send(32'h4044, 16);
    ddsl_host_inst.send(32'h4088, 16);
    ddsl_host_inst.send(32'h40CC, 16);
    expect_out({10'h3FF, 10'h0F0, 10'h0F0, 2'h2});
    out_ready <= 1'h1;
    repeat (8) @(posedge clock);
    expect_out({10'h3FF, 10'h022, 10'h022, 2'h2});
    expect_cnt({10'h10F, 10'h022, 10'h022, 2'h2});
    end_sim();
  end
endmodule
